// file: pkg/adcc_defs.svh
/*
  Offsets, field positions, reset values and timing counts of the converter control.
  Assumes a plain register port with 8-bit addresses and 16-bit data.
*/
// Overview of operation
// RL1: Staged selection copies to active while idle.
// RL2: Active selection frozen during a conversion.
// RL3: Copying resumes in the final converter cycle.
// RL4: Start begins at next converter clock edge.
// RL5: Software changes channel only after start.
// RL6: Free-run: next result uses previous channel.
// RL7: Over-reference input saturates at full scale.
// RL8: Temperature channel code turns sensor on.
// RL9: Temperature reading needs internal reference code.
// RL10: Temperature reading needs long delays, small capacitance.
// RL11: Window hit sets flag, may request interrupt.
// RL12: Comparator works only with non-zero mode.
// RL13: Accumulation compares once, after last sample.
// RL14: Enabled routed event starts like software start.
// RL15: Enabled converter pulses result-ready event once.
// RL16: Flags set even with interrupt disabled.
// RL17: Request held while enabled flag stays set.
// RL18: Standby stops converter unless run-in-standby set.
// RL19: Standby requests clock only while converting.
// RL20: Event edge sets start bit; completion clears.
// RL21: Non-zero initial delay postpones first standby conversion.
// RL22: Power-down halts; completion flags invalid result.
// RL23: Start bit stays one during conversion.
// RL24: Result read or write-one clears ready.
// RL25: Plain conversion lasts thirteen converter cycles.
// RL26: Result is right-adjusted.
// RL27: Comparator checks final unsigned result value.
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ADCC_OFS_CTRL 8'h00
`define ADCC_OFS_SELECT 8'h01
`define ADCC_OFS_TIMING 8'h02
`define ADCC_OFS_COMMAND 8'h03
`define ADCC_OFS_INTERRUPT_CONTROL 8'h04
`define ADCC_OFS_INTERRUPT_FLAGS 8'h05
`define ADCC_OFS_RESULT 8'h06
`define ADCC_OFS_WINDOW_LOW_THRESHOLD 8'h07
`define ADCC_OFS_WINDOW_HIGH_THRESHOLD 8'h08
`define ADCC_OFS_ACTIVE 8'h09

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ADCC_CTRL_ENABLE 0
`define ADCC_CTRL_FREERUN 1
`define ADCC_CTRL_RES8 2
`define ADCC_CTRL_RUN_IN_STANDBY 3
`define ADCC_CTRL_START_EVENT_INPUT_ENABLE 4
`define ADCC_CTRL_ACCUM 5
`define ADCC_CTRL_PRESC 8
`define ADCC_CTRL_SAMPLE_CAPACITANCE_SELECT 11
`define ADCC_SEL_CHAN 0
`define ADCC_SEL_REF 5
`define ADCC_TIM_SAMPLE_LENGTH 0
`define ADCC_TIM_INITIAL_DELAY 5
`define ADCC_TIM_WINMODE 8
`define ADCC_FLAG_RDY 0
`define ADCC_FLAG_WINDOW_COMPARE_FLAG 1
`define ADCC_FLAG_INVALID 2

// ----------------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------------
`define ADCC_REG_RST 16'h0000
`define ADCC_CONV_CYCLES 13
`define ADCC_HOLD_TICK 6'h01
`define ADCC_INITIAL_DELAY_UNIT 7'h10
`define ADCC_TEMP_CHANNEL 5'h1e
`define ADCC_FULL_SCALE 10'h3ff
`define ADCC_ACCUM_MAX 3'h6

`endif

// file: pkg/adcc_pkg.sv
/*
  Types shared by the converter control modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package adcc_pkg;

  typedef enum {ST_IDLE, ST_ARM, ST_DELAY, ST_CONV} adcc_state_t;

  typedef enum logic [2:0] {WIN_OFF, WIN_BELOW, WIN_ABOVE, WIN_INSIDE, WIN_OUTSIDE} adcc_win_mode_t;

endpackage : adcc_pkg

// file: pkg/adcc_win_if.sv
/*
  Carrier between the control core and the window comparator.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface adcc_win_if;
  logic [15:0] result;
  logic [15:0] low;
  logic [15:0] high;
  logic [2:0] mode;
  logic strobe;
  logic hit;
  modport ctl (output result, low, high, mode, strobe, input hit);
  modport cmp (input result, low, high, mode, strobe, output hit);
endinterface : adcc_win_if

// file: hdl/adcc_window.sv
/*
  Window comparator: checks each final result against the thresholds.
  Assumes a one-cycle strobe beside a stable result from the control core.
*/
`timescale 1ns/1ps
module adcc_window
  import adcc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Comparator side of the carrier
  adcc_win_if.cmp win
);

  // ----------------------------------------------------------------------
  // Comparison
  // ----------------------------------------------------------------------
  logic next_hit;

  always_comb begin
    case (adcc_win_mode_t'(win.mode))
      WIN_BELOW: next_hit = win.result < win.low; // [RL11] [RL27]
      WIN_ABOVE: next_hit = win.result > win.high;
      WIN_INSIDE: next_hit = (win.result > win.low) && (win.result < win.high);
      WIN_OUTSIDE: next_hit = (win.result < win.low) || (win.result > win.high);
      default: next_hit = 1'b0; // [RL12]
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      win.hit <= 1'b0;
    end else begin
      win.hit <= win.strobe && next_hit;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_mode_off_quiet: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // [RL12]
    (win.mode == 3'h0) |=> !win.hit)
    else $error("Comparator hit with mode off.");

  a_hit_needs_strobe: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // [RL13]
    win.hit |-> $past(win.strobe))
    else $error("Comparator hit without a final result.");

endmodule : adcc_window

// file: hdl/adcc_top.sv
/*
  Conversion control core: registers, prescaler, sequencer, accumulation and flags.
  Assumes the converter front end presents an 11-bit level on the system clock,
  and that sleep and event inputs come from logic on the same clock.
*/
`timescale 1ns/1ps
`include "adcc_defs.svh"
module adcc_top
  import adcc_pkg::*;
#(
  parameter int CONV_CYCLES = `ADCC_CONV_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [15:0] reg_rdata_o,
  // Event routing
  input wire logic event_start_i,
  output logic result_event_o,
  // Sleep control
  input wire logic sleep_standby_i,
  input wire logic sleep_powerdown_i,
  output logic clk_request_o,
  // Converter front end
  input wire logic [10:0] analog_level_i,
  output logic [4:0] input_channel_select_o,
  output logic [1:0] reference_select_o,
  output logic temp_sensor_on_o,
  output logic sample_capacitance_select_o,
  // Interrupt
  output logic irq_o
);

  if (CONV_CYCLES < 4 || CONV_CYCLES > 32) begin : g_bad_len
    $error("CONV_CYCLES out of range.");
  end

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic enable, freerun, res8, run_in_standby, start_event_input_enable;
  logic sample_capacitance_select;
  logic [2:0] accum_select, presc_select, initial_delay, window_compare_mode;
  logic [4:0] stage_chan, sample_length;
  logic [1:0] stage_ref;
  logic start_conversion_bit, rdy_en, window_compare_flag_en;
  logic result_ready_flag, window_compare_flag, result_invalid;
  logic [15:0] result_register, window_low_threshold, window_high_threshold, acc;
  logic [9:0] sample;
  adcc_state_t state;
  logic [8:0] presc_cnt;
  logic [5:0] cnt, samp_cnt;
  logic [6:0] dly_cnt;
  logic first_pending, standby_q, event_q, halted_seen;

  logic run_ok, tick, wr_cmd, event_edge, start_req, last_cyc, done, final_done;
  logic rd_result, copy_sel, use_delay, final_cyc;
  logic [5:0] conv_len, samp_last;
  logic [8:0] presc_top;
  logic [2:0] accum_n;
  logic [15:0] acc_sum;
  logic [9:0] level_sat, next_sample;

  adcc_win_if win ();

  // ----------------------------------------------------------------------
  // Control terms
  // ----------------------------------------------------------------------
  assign run_ok = enable && !sleep_powerdown_i && !(sleep_standby_i && !run_in_standby); // [RL18] [RL22]
  assign presc_top = 9'((10'h002 << presc_select) - 10'h001);
  assign tick = (state != ST_IDLE) && run_ok && (presc_cnt == presc_top);
  assign conv_len = 6'(CONV_CYCLES) + {1'b0, sample_length}; // [RL25]
  assign last_cyc = (state == ST_CONV) && (cnt == conv_len - 6'h01);
  assign final_cyc = last_cyc && (samp_cnt == samp_last);
  assign copy_sel = (state != ST_CONV) || final_cyc; // [RL1] [RL2] [RL3]
  assign done = tick && last_cyc;
  assign accum_n = (accum_select > `ADCC_ACCUM_MAX) ? `ADCC_ACCUM_MAX : accum_select;
  assign samp_last = 6'((7'h01 << accum_n) - 7'h01);
  assign final_done = done && (samp_cnt == samp_last); // [RL13]
  assign acc_sum = acc + {6'h00, sample};
  assign level_sat = analog_level_i[10] ? `ADCC_FULL_SCALE : analog_level_i[9:0]; // [RL7]
  assign next_sample = res8 ? {2'b00, level_sat[9:2]} : level_sat; // [RL26]
  assign wr_cmd = reg_write_i && (reg_addr_i == `ADCC_OFS_COMMAND) && reg_wdata_i[0];
  assign event_edge = event_start_i && !event_q; // [RL20]
  assign start_req = enable && (wr_cmd || (start_event_input_enable && event_edge)); // [RL14]
  assign rd_result = reg_read_i && (reg_addr_i == `ADCC_OFS_RESULT);
  assign use_delay = first_pending && sleep_standby_i && (initial_delay != 3'h0);

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      {enable, freerun, res8, run_in_standby, start_event_input_enable} <= 5'h00;
      {accum_select, presc_select, sample_capacitance_select} <= 7'h00;
      {stage_chan, stage_ref} <= 7'h00;
      {sample_length, initial_delay, window_compare_mode} <= 11'h000;
      {rdy_en, window_compare_flag_en} <= 2'h0;
      window_low_threshold <= `ADCC_REG_RST;
      window_high_threshold <= `ADCC_REG_RST;
    end else if (reg_write_i) begin
      case (reg_addr_i)
        `ADCC_OFS_CTRL: begin
          enable <= reg_wdata_i[`ADCC_CTRL_ENABLE];
          freerun <= reg_wdata_i[`ADCC_CTRL_FREERUN];
          res8 <= reg_wdata_i[`ADCC_CTRL_RES8];
          run_in_standby <= reg_wdata_i[`ADCC_CTRL_RUN_IN_STANDBY];
          start_event_input_enable <= reg_wdata_i[`ADCC_CTRL_START_EVENT_INPUT_ENABLE];
          accum_select <= reg_wdata_i[`ADCC_CTRL_ACCUM +: 3];
          presc_select <= reg_wdata_i[`ADCC_CTRL_PRESC +: 3];
          sample_capacitance_select <= reg_wdata_i[`ADCC_CTRL_SAMPLE_CAPACITANCE_SELECT];
        end
        `ADCC_OFS_SELECT: begin
          stage_chan <= reg_wdata_i[`ADCC_SEL_CHAN +: 5];
          stage_ref <= reg_wdata_i[`ADCC_SEL_REF +: 2];
        end
        `ADCC_OFS_TIMING: begin
          sample_length <= reg_wdata_i[`ADCC_TIM_SAMPLE_LENGTH +: 5];
          initial_delay <= reg_wdata_i[`ADCC_TIM_INITIAL_DELAY +: 3];
          window_compare_mode <= reg_wdata_i[`ADCC_TIM_WINMODE +: 3];
        end
        `ADCC_OFS_INTERRUPT_CONTROL: begin
          rdy_en <= reg_wdata_i[`ADCC_FLAG_RDY];
          window_compare_flag_en <= reg_wdata_i[`ADCC_FLAG_WINDOW_COMPARE_FLAG];
        end
        `ADCC_OFS_WINDOW_LOW_THRESHOLD: window_low_threshold <= reg_wdata_i;
        `ADCC_OFS_WINDOW_HIGH_THRESHOLD: window_high_threshold <= reg_wdata_i;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Active selection
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      input_channel_select_o <= 5'h00;
      reference_select_o <= 2'h0;
      temp_sensor_on_o <= 1'b0;
      sample_capacitance_select_o <= 1'b0;
    end else begin
      if (copy_sel && enable) begin // [RL1] [RL3]
        input_channel_select_o <= stage_chan;
        reference_select_o <= stage_ref;
      end
      temp_sensor_on_o <= enable && (input_channel_select_o == `ADCC_TEMP_CHANNEL); // [RL8]
      sample_capacitance_select_o <= sample_capacitance_select;
    end
  end

  // ----------------------------------------------------------------------
  // Prescaler, kept reset while no conversion is pending
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      presc_cnt <= 9'h000;
    end else if (state == ST_IDLE || !enable) begin
      presc_cnt <= 9'h000;
    end else if (run_ok) begin
      presc_cnt <= tick ? 9'h000 : presc_cnt + 9'h001;
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      state <= ST_IDLE;
      start_conversion_bit <= 1'b0;
      cnt <= 6'h00;
      dly_cnt <= 7'h00;
      samp_cnt <= 6'h00;
      acc <= 16'h0000;
      sample <= 10'h000;
      result_register <= 16'h0000;
    end else if (!enable) begin
      state <= ST_IDLE;
      start_conversion_bit <= 1'b0;
      samp_cnt <= 6'h00;
      acc <= 16'h0000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start_req) begin // [RL4] [RL20]
            state <= ST_ARM;
            start_conversion_bit <= 1'b1; // [RL23]
          end
        end
        ST_ARM: begin
          if (tick && use_delay) begin // [RL21]
            state <= ST_DELAY;
            dly_cnt <= 7'(initial_delay * `ADCC_INITIAL_DELAY_UNIT);
          end else if (tick) begin // [RL4]
            state <= ST_CONV;
            cnt <= 6'h00;
          end
        end
        ST_DELAY: begin
          if (tick) begin
            dly_cnt <= dly_cnt - 7'h01;
            if (dly_cnt == 7'h01) begin
              state <= ST_CONV;
              cnt <= 6'h00;
            end
          end
        end
        ST_CONV: begin
          if (tick) begin
            cnt <= cnt + 6'h01;
          end
          if (tick && cnt == `ADCC_HOLD_TICK) begin
            sample <= next_sample;
          end
          if (done) begin
            cnt <= 6'h00;
            if (!final_done) begin
              samp_cnt <= samp_cnt + 6'h01;
              acc <= acc_sum;
            end else begin
              samp_cnt <= 6'h00;
              acc <= 16'h0000;
              result_register <= acc_sum; // [RL26] [RL27]
              if (!(freerun && start_conversion_bit)) begin // [RL6]
                state <= ST_IDLE;
                start_conversion_bit <= 1'b0; // [RL20]
              end
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Standby tracking and sleep effects
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      standby_q <= 1'b0;
      event_q <= 1'b0;
      first_pending <= 1'b0;
      halted_seen <= 1'b0;
      clk_request_o <= 1'b0;
    end else begin
      standby_q <= sleep_standby_i;
      event_q <= event_start_i;
      if (sleep_standby_i && !standby_q) begin
        first_pending <= 1'b1;
      end else if (state == ST_ARM && tick) begin
        first_pending <= 1'b0;
      end
      if (state == ST_ARM) begin
        halted_seen <= 1'b0;
      end else if (state != ST_IDLE && sleep_powerdown_i) begin
        halted_seen <= 1'b1; // [RL22]
      end
      clk_request_o <= sleep_standby_i && run_in_standby && (state != ST_IDLE); // [RL19]
    end
  end

  // ----------------------------------------------------------------------
  // Flags, event and interrupt
  // ----------------------------------------------------------------------
  assign win.result = acc_sum;
  assign win.low = window_low_threshold;
  assign win.high = window_high_threshold;
  assign win.mode = window_compare_mode;
  assign win.strobe = final_done;

  adcc_window u_window (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .win(win)
  );

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      result_ready_flag <= 1'b0;
      window_compare_flag <= 1'b0;
      result_invalid <= 1'b0;
      result_event_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      if (final_done) begin // [RL16] [RL22]
        result_ready_flag <= 1'b1;
        result_invalid <= halted_seen || sleep_powerdown_i;
      end else if (rd_result || (reg_write_i && reg_addr_i == `ADCC_OFS_INTERRUPT_FLAGS
          && reg_wdata_i[`ADCC_FLAG_RDY])) begin
        result_ready_flag <= 1'b0; // [RL24]
      end
      if (win.hit) begin // [RL11] [RL16]
        window_compare_flag <= 1'b1;
      end else if (reg_write_i && reg_addr_i == `ADCC_OFS_INTERRUPT_FLAGS
          && reg_wdata_i[`ADCC_FLAG_WINDOW_COMPARE_FLAG]) begin
        window_compare_flag <= 1'b0;
      end
      result_event_o <= final_done && enable; // [RL15]
      irq_o <= (result_ready_flag && rdy_en) || (window_compare_flag && window_compare_flag_en); // [RL17]
    end
  end

  // ----------------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_read_i) begin
      case (reg_addr_i)
        `ADCC_OFS_CTRL: reg_rdata_o <= {4'h0, sample_capacitance_select, presc_select,
          accum_select, start_event_input_enable, run_in_standby, res8, freerun, enable};
        `ADCC_OFS_SELECT: reg_rdata_o <= {9'h000, stage_ref, stage_chan};
        `ADCC_OFS_TIMING: reg_rdata_o <= {5'h00, window_compare_mode, initial_delay,
          sample_length};
        `ADCC_OFS_COMMAND: reg_rdata_o <= {15'h0000, start_conversion_bit};
        `ADCC_OFS_INTERRUPT_CONTROL: reg_rdata_o <= {14'h0000, window_compare_flag_en, rdy_en};
        `ADCC_OFS_INTERRUPT_FLAGS: reg_rdata_o <= {13'h0000, result_invalid, window_compare_flag,
          result_ready_flag};
        `ADCC_OFS_RESULT: reg_rdata_o <= result_register;
        `ADCC_OFS_WINDOW_LOW_THRESHOLD: reg_rdata_o <= window_low_threshold;
        `ADCC_OFS_WINDOW_HIGH_THRESHOLD: reg_rdata_o <= window_high_threshold;
        `ADCC_OFS_ACTIVE: reg_rdata_o <= {9'h000, reference_select_o, input_channel_select_o};
        default: reg_rdata_o <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_locked;
    (state == ST_CONV) && !final_cyc && enable;
  endsequence

  a_busy_bit_high: assert property ((state != ST_IDLE) |-> start_conversion_bit) // [RL23]
    else $error("Start bit low during conversion.");

  a_sel_frozen: assert property ((s_locked ##1 s_locked) |-> $stable(input_channel_select_o)) // [RL2]
    else $error("Channel changed while locked.");

  a_sel_resume: assert property ((final_cyc && enable) |=> // [RL3]
    (input_channel_select_o == $past(stage_chan)))
    else $error("Channel not copied in last cycle.");

  a_start_edge: assert property ((state == ST_ARM && tick && !use_delay) |=> // [RL4]
    (state == ST_CONV) && (cnt == 6'h00))
    else $error("Conversion not started at converter edge.");

  a_ready_set: assert property (final_done |=> result_ready_flag && result_event_o) // [RL16]
    else $error("Completion did not set ready.");

  a_event_pulse: assert property (result_event_o |=> !result_event_o) // [RL15]
    else $error("Result event longer than one cycle.");

  a_irq_follow: assert property ((result_ready_flag && rdy_en) |=> irq_o) // [RL17]
    else $error("Request missing for enabled flag.");

  a_sat_value: assert property ((state == ST_CONV && tick && cnt == `ADCC_HOLD_TICK // [RL7]
    && analog_level_i[10] && !res8) |=> (sample == `ADCC_FULL_SCALE))
    else $error("Over-range input not saturated.");

  a_conv_length: assert property ((state == ST_ARM && tick && !use_delay && run_ok // [RL25]
    && presc_select == 3'h0 && sample_length == 5'h00 && !sleep_standby_i
    && !sleep_powerdown_i) |=> (state == ST_CONV) [*8])
    else $error("Conversion ended too early.");

endmodule : adcc_top

// file: bench/adcc_src_model.sv
/*
  Model of the far side: analog sources per channel and the event router.
  Assumes the bench pulses fire_i for one cycle to send an event.
*/
`timescale 1ns/1ps
module adcc_src_model (
  // Clock
  input wire logic clk_sys_i,
  // Converter side
  input wire logic [4:0] chan_i,
  output logic [10:0] level_o,
  // Event side
  input wire logic fire_i,
  output logic event_o
);
  logic [1:0] hold = 2'h0;
  // Channel 5'h1f lies above the reference.
  assign level_o = (chan_i == 5'h1f) ? 11'h5aa : {1'b0, chan_i, 5'h15};
  always @(posedge clk_sys_i) begin
    if (fire_i) begin
      hold <= 2'h3;
    end else if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end
  end
  assign event_o = (hold != 2'h0);
endmodule : adcc_src_model

// file: bench/test_adc_conversion_control.sv
/*
  Self-checking bench of the converter control with random and corner conversions.
  Assumes the source model; the bench drives the sleep inputs.
*/
`timescale 1ns/1ps
`include "adcc_defs.svh"
module test_adc_conversion_control;
  import adcc_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic fire = 1'b0;
  logic sb = 1'b0;
  logic pd = 1'b0;
  logic [15:0] reg_rdata, rv;
  logic [10:0] level;
  logic [4:0] chan_act;
  logic [1:0] ref_act;
  logic ev_start, res_ev, clk_req, temp_on, cap_sel, irq;
  int errors = 0;
  int cmp_count = 0;
  always #12.5 clk_sys_i = ~clk_sys_i;
  adcc_top i_adcc_top (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_write_i(reg_write), .reg_read_i(reg_read),
    .reg_rdata_o(reg_rdata), .event_start_i(ev_start), .result_event_o(res_ev),
    .sleep_standby_i(sb), .sleep_powerdown_i(pd), .clk_request_o(clk_req),
    .analog_level_i(level), .input_channel_select_o(chan_act), .reference_select_o(ref_act),
    .temp_sensor_on_o(temp_on), .sample_capacitance_select_o(cap_sel), .irq_o(irq));
  adcc_src_model i_adcc_src_model (.clk_sys_i(clk_sys_i), .chan_i(chan_act), .level_o(level),
    .fire_i(fire), .event_o(ev_start));
  // ----------------------------------------------------------------------
  // Bus tasks and expectations
  // ----------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys_i);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys_i);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys_i);
    reg_read <= 1'b0;
    @(negedge clk_sys_i);
    d = reg_rdata;
  endtask : rd
  function automatic logic [15:0] exp_res(input logic [4:0] c, input int acc);
    logic [15:0] s;
    s = (c == 5'h1f) ? 16'h03ff : {6'h00, c, 5'h15};
    return s << acc;
  endfunction : exp_res
  function automatic logic win_hit(input int m, input logic [15:0] r, lo, hi);
    case (m)
      1: return r < lo;
      2: return r > hi;
      3: return (r > lo) && (r < hi);
      4: return (r < lo) || (r > hi);
      default: return 1'b0;
    endcase
  endfunction : win_hit
  task automatic conv(input logic [4:0] c, input int acc, input int m, input logic [15:0] lo,
                      input logic [15:0] hi, input logic ie, input logic ev);
    logic [15:0] r;
    int n;
    int p;
    r = exp_res(c, acc);
    p = (c == 5'h1e) ? 7 : 0;
    wr(`ADCC_OFS_SELECT, {11'h000, c});
    wr(`ADCC_OFS_TIMING, (16'(m) << 8) | ((c == 5'h1e) ? 16'h0025 : 16'h0000));
    wr(`ADCC_OFS_WINDOW_LOW_THRESHOLD, lo);
    wr(`ADCC_OFS_WINDOW_HIGH_THRESHOLD, hi);
    wr(`ADCC_OFS_INTERRUPT_CONTROL, {15'h0000, ie});
    wr(`ADCC_OFS_CTRL, 16'h0001 | (16'(ev) << 4) | (16'(acc) << 5) | (16'(p) << 8)
       | (16'(c == 5'h1e) << 11));
    if (ev) begin
      @(posedge clk_sys_i);
      fire <= 1'b1;
      @(posedge clk_sys_i);
      fire <= 1'b0;
    end else begin
      wr(`ADCC_OFS_COMMAND, 16'h0001);
    end
    rd(`ADCC_OFS_COMMAND, rv);
    chk(rv & 16'h0001, 16'h0001, "busy bit");
    chk(16'(chan_act), 16'(c), "active channel");
    chk(16'(temp_on), 16'(c == 5'h1e), "sensor enable");
    chk(16'(ref_act), 16'h0000, "active reference");
    chk(16'(cap_sel), 16'(c == 5'h1e), "capacitance");
    repeat (4 << p) @(posedge clk_sys_i);
    wr(`ADCC_OFS_SELECT, {11'h000, c ^ 5'h01});
    @(negedge clk_sys_i);
    chk(16'(chan_act), 16'(c), "frozen channel");
    n = 0;
    while (res_ev !== 1'b1 && n < 20000) begin
      @(negedge clk_sys_i);
      n++;
    end
    chk(16'(n < 20000), 16'h0001, "no result event");
    @(negedge clk_sys_i);
    chk(16'(res_ev), 16'h0000, "event width");
    chk(16'(irq), 16'(ie), "ready request");
    rd(`ADCC_OFS_COMMAND, rv);
    chk(rv & 16'h0001, 16'h0000, "busy after end");
    rd(`ADCC_OFS_INTERRUPT_FLAGS, rv);
    chk(rv, {14'h0000, win_hit(m, r, lo, hi), 1'b1}, "flags");
    rd(`ADCC_OFS_RESULT, rv);
    chk(rv, r, "result");
    rd(`ADCC_OFS_INTERRUPT_FLAGS, rv);
    chk(rv & 16'h0001, 16'h0000, "ready after read");
    wr(`ADCC_OFS_INTERRUPT_FLAGS, 16'h0002);
    rd(`ADCC_OFS_INTERRUPT_FLAGS, rv);
    chk(rv, 16'h0000, "flags cleared");
    chk(16'(irq), 16'h0000, "request dropped");
    chk(16'(chan_act), 16'(c ^ 5'h01), "channel resumed");
    $display("conversion test on channel %0d done", c);
  endtask : conv
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  // ----------------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    rv = $urandom(32'h7092c251);
    repeat (6) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    rd(`ADCC_OFS_CTRL, rv);
    chk(rv, 16'h0000, "control reset");
    rd(8'h0f, rv);
    chk(rv, 16'h0000, "unmapped read");
    $display("reset test done");
    for (int m = 0; m < 5; m++) begin
      conv(5'h10, 0, m, 16'h0200, 16'h0300, 1'b0, 1'b0);
    end
    conv(5'h1f, 0, 2, 16'h0000, 16'h03fe, 1'b1, 1'b0);
    conv(5'h1e, 2, 4, 16'h0100, 16'h0f00, 1'b1, 1'b1);
    for (int i = 0; i < 8; i++) begin
      conv(5'($urandom % 30), $urandom % 3, $urandom % 5, 16'($urandom & 16'h0fff),
           16'($urandom & 16'h0fff), 1'($urandom), 1'($urandom));
    end
    wr(`ADCC_OFS_TIMING, 16'h0020);
    wr(`ADCC_OFS_SELECT, 16'h0004);
    wr(`ADCC_OFS_CTRL, 16'h0007);
    wr(`ADCC_OFS_COMMAND, 16'h0001);
    repeat (4) @(posedge clk_sys_i);
    wr(`ADCC_OFS_SELECT, 16'h0005);
    @(posedge res_ev);
    rd(`ADCC_OFS_RESULT, rv);
    chk(rv, 16'h0025, "old channel");
    @(posedge res_ev);
    rd(`ADCC_OFS_RESULT, rv);
    chk(rv, 16'h002d, "new channel");
    wr(`ADCC_OFS_CTRL, 16'h0009);
    repeat (40) @(posedge clk_sys_i);
    $display("free-run test done");
    sb <= 1'b1;
    wr(`ADCC_OFS_COMMAND, 16'h0001);
    repeat (40) @(negedge clk_sys_i);
    chk(16'(clk_req), 16'h0001, "clock request");
    @(posedge clk_sys_i);
    pd <= 1'b1;
    repeat (40) @(posedge clk_sys_i);
    rd(`ADCC_OFS_COMMAND, rv);
    chk(rv, 16'h0001, "halted busy");
    @(posedge clk_sys_i);
    pd <= 1'b0;
    repeat (100) @(negedge clk_sys_i);
    chk(16'(clk_req), 16'h0000, "clock released");
    rd(`ADCC_OFS_INTERRUPT_FLAGS, rv);
    chk(rv, 16'h0005, "invalid result");
    $display("sleep test done");
    report_and_stop();
  end
  initial begin
    #1000000;
    errors++;
    report_and_stop();
  end
endmodule : test_adc_conversion_control
